/* rtl/out_term_status.sv */
// Output terminal status select: status flags, fault latches, pulse train and
// per-terminal function routing behind an Avalon-MM register slave.
// Assumes drive status inputs are synchronous to clk_i and fault inputs are levels.
//
// Function
// - Codes 91/191 route power-off fault flag
// - Codes 93/193 pulse train, refused on relay
// - Codes 95/195 route maintenance timer flag
// - Codes 96/196 drive remote output bit
// - Codes 98/198 route minor alarm flag
// - Codes 99/199 route latched fault flag
// - Same function on many terminals drives identically, except remote output bits
// - Low codes conduct active, high codes invert
// - Ready when startable, also while running
// - Running at or above starting frequency, off braking
// - Ready codes 11/111, running codes 0/100
// - Ready drops on fault, shutoff, coasting power loss with no start command
// - Running terminal defaults to running, positive
// - Relay terminal defaults to fault output
// - Power-off fault from listed internal faults
// - Earth fault shown as overcurrent still power-off
// - Up-to-frequency routed unfiltered from its source
`timescale 1ns/1ps

module out_term_status #(
	parameter int FREQ_W  = 16,
	parameter int MAINT_W = 16,
	parameter int AVG_W   = 8
) (
	// Clock, reset, enable
	input  wire logic                              clk_i,
	input  wire logic                              rst_i,
	input  wire logic                              ce_i,
	// Avalon-MM slave
	input  wire logic [out_term_pkg::ADDR_W-1:0]   avs_address_i,
	input  wire logic                              avs_read_i,
	input  wire logic                              avs_write_i,
	input  wire logic [31:0]                       avs_writedata_i,
	input  wire logic [3:0]                        avs_byteenable_i,
	output logic [31:0]                            avs_readdata_o,
	output logic                                   avs_waitrequest_o,
	// Drive state
	input  wire logic [FREQ_W-1:0]                 output_freq_i,
	input  wire logic                              start_cmd_i,
	input  wire logic                              dc_brake_i,
	input  wire logic                              output_shutoff_input_i,
	input  wire logic                              coasting_i,
	input  wire logic                              restarting_i,
	input  wire logic                              power_fail_i,
	input  wire logic                              undervoltage_i,
	input  wire logic                              up_to_frequency_flag_i,
	input  wire logic [AVG_W-1:0]                  avg_current_i,
	input  wire logic                              maint_tick_i,
	// Fault and warning sources
	input  wire logic                              brake_alarm_i,
	input  wire logic                              earth_fault_trip_i,
	input  wire logic                              accel_overcurrent_trip_i,
	input  wire logic                              phase_loss_i,
	input  wire logic                              storage_fault_i,
	input  wire logic                              board_fault_i,
	input  wire logic                              cpu_fault_i,
	input  wire logic                              inrush_fault_i,
	input  wire logic                              other_trip_i,
	input  wire logic                              fan_fail_i,
	input  wire logic                              comm_warn_i,
	// Terminals and flags
	output logic [out_term_pkg::NUM_TERM-1:0]      terminal_o,
	output logic                                   operation_ready_flag_o,
	output logic                                   running_flag_o,
	output logic                                   fault_flag_o,
	output logic                                   power_off_fault_flag_o
);

	localparam int NT = out_term_pkg::NUM_TERM;
	localparam int CW = out_term_pkg::CODE_W;

	typedef struct packed {
		logic [NT-1:0][CW-1:0] sel;
		logic [NT-1:0]         remote;
		logic [MAINT_W-1:0]    maint_count;
		logic [MAINT_W-1:0]    maint_thresh;
		logic [FREQ_W-1:0]     start_freq;
		logic                  fault;
		logic                  pof;
		logic                  init_done;
		logic                  ack;
		logic [31:0]           rdata;
		logic [NT-1:0]         term;
		logic [7:0]            pulse_cnt;
		logic                  pulse_phase;
		logic                  pulse;
	} state_t;

	state_t q;
	state_t next_q;

	logic            req;
	logic            wr_commit;
	logic            fault_clr;
	logic            pof_src;
	logic            fault_src;
	logic            ready;
	logic            running;
	logic            maint_flag;
	logic            minor_alarm_flag;
	logic [31:0]     rd_val;
	logic [31:0]     wr_val;
	logic [31:0]     status;
	logic [NT-1:0]   drive;
	logic [7:0]      pulse_level;

	// Byte address of a terminal's selection register
	function automatic logic [out_term_pkg::ADDR_W-1:0] sel_addr(input int i);
		logic [out_term_pkg::ADDR_W-1:0] idx;
		idx = i[out_term_pkg::ADDR_W-1:0];
		return out_term_pkg::OFF_SEL0 + idx * out_term_pkg::SEL_STRIDE;
	endfunction : sel_addr

	// Whether a code may be stored in a terminal's selection
	function automatic logic code_ok(input logic [CW-1:0] code, input logic relay);
		logic pulse_code;
		pulse_code = (code == out_term_pkg::F_PULSE)
			|| (code == out_term_pkg::F_PULSE + out_term_pkg::NEG_OFFSET);
		return ((code <= out_term_pkg::NEG_LAST) || (code == out_term_pkg::NO_FUNC))
			&& !(relay && pulse_code);
	endfunction : code_ok

	// Merge write data into an old word under byte enables
	function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] wd,
		input logic [3:0] be);
		logic [31:0] res;
		res = old;
		for (int b = 0; b < 4; b++) begin
			if (be[b]) begin
				res[b*8 +: 8] = wd[b*8 +: 8];
			end
		end
		return res;
	endfunction : be_merge

	// Bus handshake: one wait cycle, then the answer
	assign req               = avs_read_i || avs_write_i;
	assign avs_waitrequest_o = req && !q.ack;
	assign wr_commit         = avs_write_i && q.ack;
	assign avs_readdata_o    = q.rdata;

	// Fault sources
	assign pof_src   = brake_alarm_i || earth_fault_trip_i || phase_loss_i
		|| storage_fault_i || board_fault_i || cpu_fault_i || inrush_fault_i;
	assign fault_src = pof_src || accel_overcurrent_trip_i || other_trip_i;

	// Drive indications
	assign ready = q.init_done && !q.fault && !output_shutoff_input_i
		&& !(coasting_i && !start_cmd_i && (power_fail_i || undervoltage_i));
	assign running = (output_freq_i >= q.start_freq) && !dc_brake_i
		&& !q.fault && !output_shutoff_input_i && !(coasting_i && !restarting_i);
	assign maint_flag       = q.maint_count >= q.maint_thresh;
	assign minor_alarm_flag = fan_fail_i || comm_warn_i;

	// Status word
	always_comb begin
		status = '0;
		status[out_term_pkg::ST_READY]       = ready;
		status[out_term_pkg::ST_RUN]         = running;
		status[out_term_pkg::ST_FAULT]       = q.fault;
		status[out_term_pkg::ST_POF]         = q.pof;
		status[out_term_pkg::ST_MAINT]       = maint_flag;
		status[out_term_pkg::ST_MINOR]       = minor_alarm_flag;
		status[out_term_pkg::ST_SU]          = up_to_frequency_flag_i;
		status[out_term_pkg::ST_PULSE]       = q.pulse;
		status[out_term_pkg::ST_TERM +: NT]  = q.term;
	end

	// Read mux; unmapped addresses read as zero
	always_comb begin
		rd_val = '0;
		for (int i = 0; i < NT; i++) begin
			if (avs_address_i == sel_addr(i)) begin
				rd_val = 32'(q.sel[i]);
			end
		end
		case (avs_address_i)
			out_term_pkg::OFF_REMOTE: rd_val = 32'(q.remote);
			out_term_pkg::OFF_MCOUNT: rd_val = 32'(q.maint_count);
			out_term_pkg::OFF_MTHR:   rd_val = 32'(q.maint_thresh);
			out_term_pkg::OFF_SFREQ:  rd_val = 32'(q.start_freq);
			out_term_pkg::OFF_STATUS: rd_val = status;
			default: ;
		endcase
	end

	assign wr_val    = be_merge(rd_val, avs_writedata_i, avs_byteenable_i);
	assign fault_clr = wr_commit && (avs_address_i == out_term_pkg::OFF_FCTL)
		&& avs_byteenable_i[0] && avs_writedata_i[out_term_pkg::FCTL_RESET];

	// Pulse train: alternate frames of average current and timer high byte
	assign pulse_level = q.pulse_phase ? q.maint_count[MAINT_W-1 -: 8] : avg_current_i[AVG_W-1 -: 8];

	// Terminal routing, one selector per terminal
	genvar g;
	generate
		for (g = 0; g < NT; g++) begin : g_term
			term_select u_sel (
				.code_i    (q.sel[g]),
				.remote_i  (q.remote[g]),
				.running_i (running),
				.ready_i   (ready),
				.su_i      (up_to_frequency_flag_i),
				.pof_i     (q.pof),
				.pulse_i   (q.pulse),
				.maint_i   (maint_flag),
				.minor_i   (minor_alarm_flag),
				.fault_i   (q.fault),
				.conduct_o (drive[g])
			);
		end
	endgenerate

	// Next state
	always_comb begin
		next_q           = q;
		next_q.ack       = req && !q.ack;
		next_q.init_done = 1'b1;
		next_q.term      = drive;
		if (req && !q.ack) begin
			next_q.rdata = avs_read_i ? rd_val : '0;
		end
		// Latched faults: a new fault wins over a clear in the same cycle
		next_q.fault = fault_src || (q.fault && !fault_clr);
		next_q.pof   = pof_src || (q.pof && !fault_clr);
		// Maintenance timer count, saturating
		if (maint_tick_i && !(&q.maint_count)) begin
			next_q.maint_count = q.maint_count + 1'b1;
		end
		// Pulse generator
		next_q.pulse = q.pulse_cnt < pulse_level;
		if (q.pulse_cnt == out_term_pkg::PULSE_LAST) begin
			next_q.pulse_cnt   = '0;
			next_q.pulse_phase = !q.pulse_phase;
		end else begin
			next_q.pulse_cnt = q.pulse_cnt + 1'b1;
		end
		// Register writes at the edge where waitrequest is low
		if (wr_commit) begin
			for (int i = 0; i < NT; i++) begin
				if (avs_address_i == sel_addr(i) && code_ok(wr_val[CW-1:0], i == out_term_pkg::RELAY_IDX)) begin
					next_q.sel[i] = wr_val[CW-1:0];
				end
			end
			case (avs_address_i)
				out_term_pkg::OFF_REMOTE: next_q.remote       = wr_val[NT-1:0];
				out_term_pkg::OFF_MCOUNT: next_q.maint_count  = wr_val[MAINT_W-1:0];
				out_term_pkg::OFF_MTHR:   next_q.maint_thresh = wr_val[MAINT_W-1:0];
				out_term_pkg::OFF_SFREQ:  next_q.start_freq   = wr_val[FREQ_W-1:0];
				default: ;
			endcase
		end
	end

	// State register with clock enable
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			q              <= '0;
			q.sel[0]       <= out_term_pkg::SEL0_RST;
			q.sel[1]       <= out_term_pkg::SEL1_RST;
			q.sel[out_term_pkg::RELAY_IDX] <= out_term_pkg::SEL2_RST;
			q.maint_thresh <= MAINT_W'(out_term_pkg::MTHR_RST);
			q.start_freq   <= FREQ_W'(out_term_pkg::SFREQ_RST);
		end else if (ce_i) begin
			q <= next_q;
		end
	end

	// Flag outputs
	assign terminal_o             = q.term;
	assign operation_ready_flag_o = ready;
	assign running_flag_o         = running;
	assign fault_flag_o           = q.fault;
	assign power_off_fault_flag_o = q.pof;

	// Checks
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	sequence s_fault_clear;
		ce_i && fault_clr && !fault_src;
	endsequence

	a_pof_sets: assert property (ce_i && earth_fault_trip_i |=> q.pof && q.fault)
		else $error("power-off fault not latched");
	a_relay_refuse: assert property (ce_i && wr_commit
		&& avs_address_i == sel_addr(out_term_pkg::RELAY_IDX) && wr_val[CW-1:0] == out_term_pkg::F_PULSE
		|=> q.sel[out_term_pkg::RELAY_IDX] == $past(q.sel[out_term_pkg::RELAY_IDX]))
		else $error("pulse code accepted on relay terminal");
	a_maint_route: assert property (ce_i && q.sel[0] == out_term_pkg::F_MAINT
		&& $stable(q.sel[0]) |=> q.term[0] == $past(maint_flag))
		else $error("maintenance flag not routed");
	a_remote_route: assert property (ce_i && q.sel[0] == out_term_pkg::F_REMOTE
		|=> q.term[0] == $past(q.remote[0]))
		else $error("remote bit not routed");
	a_minor_route: assert property (ce_i && q.sel[0] == out_term_pkg::F_MINOR && fan_fail_i
		|=> q.term[0])
		else $error("minor alarm not routed");
	a_fault_hold: assert property (ce_i && q.fault && !fault_clr |=> q.fault)
		else $error("fault dropped without reset");
	a_fault_release: assert property (q.fault ##0 s_fault_clear |=> !q.fault)
		else $error("fault not released by reset");
	a_same_func: assert property (ce_i && q.sel[0] == q.sel[1]
		&& q.sel[0] != out_term_pkg::F_REMOTE |=> q.term[0] == q.term[1])
		else $error("same function drives differently");
	a_neg_polarity: assert property (ce_i && q.sel[1] == out_term_pkg::F_FAULT + out_term_pkg::NEG_OFFSET
		&& q.fault |=> !q.term[1])
		else $error("negative polarity conducts while active");
	a_ready_drop: assert property (output_shutoff_input_i || q.fault |-> !ready)
		else $error("ready during shutoff or fault");
	a_run_brake: assert property (dc_brake_i |-> !running)
		else $error("running during dc braking");
	a_no_func: assert property (ce_i && q.sel[0] == out_term_pkg::NO_FUNC |=> !q.term[0])
		else $error("no-function terminal conducts");
	a_bus_answer: assert property (ce_i && avs_waitrequest_o |=> !avs_waitrequest_o || !req)
		else $error("bus answer late");

endmodule : out_term_status

/* include/out_term_pkg.sv */
// Constants for the output terminal status select block: codes, register map,
// reset values and status field positions.
// Assumes a 32-bit Avalon-MM slave with byte addresses and word-aligned registers.
package out_term_pkg;

	// Selection code width and function codes (positive polarity)
	localparam int              CODE_W     = 14;
	localparam logic [13:0]     F_RUN      = 14'h0000;
	localparam logic [13:0]     F_SU       = 14'h0001;
	localparam logic [13:0]     F_FDET     = 14'h0004;
	localparam logic [13:0]     F_READY    = 14'h000B;
	localparam logic [13:0]     F_POF      = 14'h005B;
	localparam logic [13:0]     F_PULSE    = 14'h005D;
	localparam logic [13:0]     F_MAINT    = 14'h005F;
	localparam logic [13:0]     F_REMOTE   = 14'h0060;
	localparam logic [13:0]     F_MINOR    = 14'h0062;
	localparam logic [13:0]     F_FAULT    = 14'h0063;
	localparam logic [13:0]     NEG_OFFSET = 14'h0064;
	localparam logic [13:0]     NEG_LAST   = 14'h00C7;
	localparam logic [13:0]     NO_FUNC    = 14'h270F;

	// Terminals: 0 running terminal, 1 open collector, 2 relay contact
	localparam int              NUM_TERM   = 3;
	localparam int              RELAY_IDX  = 2;

	// Register byte offsets
	localparam int              ADDR_W     = 6;
	localparam logic [5:0]      OFF_SEL0   = 6'h00;
	localparam logic [5:0]      SEL_STRIDE = 6'h04;
	localparam logic [5:0]      OFF_REMOTE = 6'h0C;
	localparam logic [5:0]      OFF_MCOUNT = 6'h10;
	localparam logic [5:0]      OFF_MTHR   = 6'h14;
	localparam logic [5:0]      OFF_SFREQ  = 6'h18;
	localparam logic [5:0]      OFF_STATUS = 6'h1C;
	localparam logic [5:0]      OFF_FCTL   = 6'h20;

	// Reset values
	localparam logic [13:0]     SEL0_RST   = F_RUN;
	localparam logic [13:0]     SEL1_RST   = F_FDET;
	localparam logic [13:0]     SEL2_RST   = F_FAULT;
	localparam logic [15:0]     SFREQ_RST  = 16'h0032;
	localparam logic [15:0]     MTHR_RST   = 16'h0024;

	// Status register bit positions
	localparam int              ST_READY   = 0;
	localparam int              ST_RUN     = 1;
	localparam int              ST_FAULT   = 2;
	localparam int              ST_POF     = 3;
	localparam int              ST_MAINT   = 4;
	localparam int              ST_MINOR   = 5;
	localparam int              ST_SU      = 6;
	localparam int              ST_PULSE   = 7;
	localparam int              ST_TERM    = 8;

	// Fault control: write one to clear the latched faults
	localparam int              FCTL_RESET = 0;

	// Last count of a pulse frame; a frame lasts 256 clock cycles
	localparam logic [7:0]      PULSE_LAST = 8'hFF;

endpackage : out_term_pkg

/* rtl/term_select.sv */
// One output terminal: picks a function by its selection code, then applies polarity.
// Assumes all flag inputs are synchronous levels; the caller registers the drive.
`timescale 1ns/1ps

module term_select (
	// Selection
	input  wire logic [out_term_pkg::CODE_W-1:0] code_i,
	input  wire logic                            remote_i,
	// Status flags
	input  wire logic                            running_i,
	input  wire logic                            ready_i,
	input  wire logic                            su_i,
	input  wire logic                            pof_i,
	input  wire logic                            pulse_i,
	input  wire logic                            maint_i,
	input  wire logic                            minor_i,
	input  wire logic                            fault_i,
	// Terminal drive, high means conducting
	output logic                                 conduct_o
);

	logic [out_term_pkg::CODE_W-1:0] base;
	logic                            neg;
	logic                            known;
	logic                            active;

	// Split the code into function and polarity
	always_comb begin
		neg  = (code_i >= out_term_pkg::NEG_OFFSET) && (code_i <= out_term_pkg::NEG_LAST);
		base = neg ? code_i - out_term_pkg::NEG_OFFSET : code_i;
	end

	// Function first, polarity afterwards
	always_comb begin
		known  = 1'b1;
		active = 1'b0;
		case (base)
			out_term_pkg::F_RUN:    active = running_i;
			out_term_pkg::F_READY:  active = ready_i;
			out_term_pkg::F_SU:     active = su_i;
			out_term_pkg::F_POF:    active = pof_i;
			out_term_pkg::F_PULSE:  active = pulse_i;
			out_term_pkg::F_MAINT:  active = maint_i;
			out_term_pkg::F_REMOTE: active = remote_i;
			out_term_pkg::F_MINOR:  active = minor_i;
			out_term_pkg::F_FAULT:  active = fault_i;
			default:                known  = 1'b0;
		endcase
		// Unknown or no-function codes never conduct
		conduct_o = known && (active ^ neg);
	end

endmodule : term_select

/* tb/term_load_model.sv */
// Load model: a controller reading the output terminals.
// Assumes terminal levels are sampled on the bench clock; high means conducting.
`timescale 1ns/1ps

module term_load_model #(
	parameter int IDX = 1
) (
	// Clock and control
	input  wire logic        clk_i,
	input  wire logic        clear_i,
	// Terminals from the block
	input  wire logic [2:0]  term_i,
	// Conducting cycles seen on the watched terminal
	output logic      [15:0] on_cnt_o
);
	// Count cycles in which the watched terminal conducts
	always @(posedge clk_i) begin
		if (clear_i) begin
			on_cnt_o <= 16'h0000;
		end else if (term_i[IDX] === 1'b1) begin
			on_cnt_o <= on_cnt_o + 16'h0001;
		end
	end
endmodule : term_load_model

/* tb/test_output_terminal_status_select.sv */
// Bench for the output terminal status select block: bus tasks, drive stimulus,
// a read monitor fed by an expectation queue, and a terminal load model.
// Assumes the package, the design and the load model are compiled first.
`timescale 1ns/1ps

module test_output_terminal_status_select;
	// Bus and bench state
	logic        clk_i;
	logic        rst_i;
	logic        ce;
	wire  [3:0]  fo;
	logic [5:0]  avs_address_i;
	logic        avs_read_i;
	logic        avs_write_i;
	logic [31:0] avs_writedata_i;
	logic [31:0] avs_readdata_o;
	logic        avs_waitrequest_o;
	logic [15:0] freq;
	logic [7:0]  drv;
	logic [10:0] flt;
	logic [7:0]  avg;
	logic        tick;
	logic [2:0]  term;
	logic        clr;
	logic [15:0] on_cnt;
	logic [63:0] q[$];
	logic [63:0] n;
	logic [31:0] r;
	logic [7:0]  dv[7];
	logic [1:0]  ev[7];
	logic [10:0] pm[8];
	int          fails;
	int          checks;
	int          k;
	localparam logic [5:0] sel1_a = out_term_pkg::OFF_SEL0 + out_term_pkg::SEL_STRIDE;
	localparam logic [5:0] sel2_a = sel1_a + out_term_pkg::SEL_STRIDE;

	// Design and terminal load
	out_term_status uut (
		.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce),
		.avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
		.avs_writedata_i(avs_writedata_i), .avs_byteenable_i(4'hF),
		.avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
		.output_freq_i(freq), .start_cmd_i(drv[0]), .dc_brake_i(drv[1]),
		.output_shutoff_input_i(drv[2]), .coasting_i(drv[3]), .restarting_i(drv[4]),
		.power_fail_i(drv[5]), .undervoltage_i(drv[6]), .up_to_frequency_flag_i(drv[7]),
		.avg_current_i(avg), .maint_tick_i(tick),
		.brake_alarm_i(flt[0]), .earth_fault_trip_i(flt[1]), .accel_overcurrent_trip_i(flt[2]),
		.phase_loss_i(flt[3]), .storage_fault_i(flt[4]), .board_fault_i(flt[5]),
		.cpu_fault_i(flt[6]), .inrush_fault_i(flt[7]), .other_trip_i(flt[8]),
		.fan_fail_i(flt[9]), .comm_warn_i(flt[10]),
		.terminal_o(term), .operation_ready_flag_o(fo[0]), .running_flag_o(fo[1]),
		.fault_flag_o(fo[2]), .power_off_fault_flag_o(fo[3])
	);
	term_load_model #(.IDX(1)) load (.clk_i(clk_i), .clear_i(clr), .term_i(term), .on_cnt_o(on_cnt));

	// Clock of 25 ns
	initial begin
		clk_i = 1'b0;
		forever #12.5 clk_i = ~clk_i;
	end

	task summarize;
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask : summarize

	task check(input string nm, input logic [31:0] e, input logic [31:0] s);
		checks++;
		if (e !== s) begin
			fails++;
			$display("ERROR %s expected %h seen %h", nm, e, s);
		end
	endtask : check

	// One bus access; a read notes its expected value and mask
	task bus(input logic w, input logic [5:0] a, input logic [31:0] d, input logic [31:0] m);
		int i;
		@(posedge clk_i);
		avs_address_i <= a;
		avs_writedata_i <= d;
		avs_write_i <= w;
		avs_read_i <= !w;
		if (!w) q.push_back({m, d & m});
		// Hold the request until the rising edge at which waitrequest is low
		for (i = 0; i < 20; i++) begin
			@(posedge clk_i);
			if (avs_waitrequest_o === 1'b0) break;
		end
		if (i == 20) begin
			fails++;
			summarize();
		end
		avs_write_i <= 1'b0;
		avs_read_i <= 1'b0;
	endtask : bus

	task wr(input logic [5:0] a, input logic [31:0] d);
		bus(1'b1, a, d, 32'h0);
	endtask : wr

	task rd(input logic [5:0] a, input logic [31:0] e);
		bus(1'b0, a, e, 32'hFFFF_FFFF);
	endtask : rd

	// Let changes settle, then read terminals and masked flags from status
	task st(input logic [2:0] t, input logic [7:0] f, input logic [7:0] m);
		repeat (3) @(posedge clk_i);
		bus(1'b0, out_term_pkg::OFF_STATUS, {21'h0, t, f}, {21'h0, 3'h7, m});
		check("flags", 32'(f[3:0] & m[3:0]), 32'(fo & m[3:0]));
	endtask : st

	task sel(input logic [13:0] a, input logic [13:0] b, input logic [13:0] c);
		wr(out_term_pkg::OFF_SEL0, 32'(a));
		wr(sel1_a, 32'(b));
		wr(sel2_a, 32'(c));
	endtask : sel

	// Compare each completed read with the oldest note
	always @(posedge clk_i) begin
		if (avs_read_i === 1'b1 && avs_waitrequest_o === 1'b0 && q.size() > 0) begin
			n = q.pop_front();
			check("readdata", n[31:0], avs_readdata_o & n[63:32]);
		end
	end

	// Main sequence
	initial begin
		dv = '{8'h00, 8'h02, 8'h04, 8'h28, 8'h48, 8'h29, 8'h18};
		ev = '{2'h3, 2'h1, 2'h0, 2'h0, 2'h0, 2'h1, 2'h3};
		pm = '{11'h001, 11'h002, 11'h008, 11'h010, 11'h020, 11'h040, 11'h080, 11'h006};
		rst_i = 1'b1;
		ce = 1'b1;
		avs_address_i = 6'h00;
		avs_read_i = 1'b0;
		avs_write_i = 1'b0;
		avs_writedata_i = 32'h0;
		freq = 16'h0000;
		drv = 8'h00;
		flt = 11'h000;
		avg = 8'h00;
		tick = 1'b0;
		clr = 1'b0;
		fails = 0;
		checks = 0;
		r = $urandom(32'h089c_deb0);
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
		// Frozen state ignores a fault source, so the relay stays clear
		@(posedge clk_i);
		ce <= 1'b0;
		flt <= 11'h100;
		repeat (4) @(posedge clk_i);
		ce <= 1'b1;
		flt <= 11'h000;
		rd(out_term_pkg::OFF_SEL0, 32'(out_term_pkg::SEL0_RST));
		rd(sel1_a, 32'(out_term_pkg::SEL1_RST));
		rd(sel2_a, 32'(out_term_pkg::SEL2_RST));
		rd(out_term_pkg::OFF_MTHR, 32'(out_term_pkg::MTHR_RST));
		rd(out_term_pkg::OFF_SFREQ, 32'(out_term_pkg::SFREQ_RST));
		wr(6'h24, $urandom());
		rd(6'h24, 32'h0);
		st(3'b000, 8'h01, 8'h03);
		// Running at the starting frequency and one step below
		sel(out_term_pkg::F_RUN, out_term_pkg::F_READY, 14'h0064);
		@(posedge clk_i);
		freq <= out_term_pkg::SFREQ_RST;
		st(3'b011, 8'h03, 8'h03);
		@(posedge clk_i);
		freq <= out_term_pkg::SFREQ_RST - 16'h0001;
		st(3'b110, 8'h01, 8'h03);
		@(posedge clk_i);
		freq <= out_term_pkg::SFREQ_RST + 16'($urandom_range(0, 999));
		// Run, braking, shutoff, coasting and restart states
		for (k = 0; k < 7; k++) begin
			@(posedge clk_i);
			drv <= dv[k];
			st({!ev[k][1], ev[k][0], ev[k][1]}, {6'h0, ev[k]}, 8'h03);
		end
		@(posedge clk_i);
		drv <= 8'h00;
		// Latched fault held after its source drops, cleared by reset
		sel(14'h0063, 14'h00C7, 14'h0063);
		@(posedge clk_i);
		flt <= 11'h100;
		@(posedge clk_i);
		flt <= 11'h000;
		st(3'b101, 8'h04, 8'h0F);
		wr(out_term_pkg::OFF_FCTL, 32'h1);
		st(3'b010, 8'h03, 8'h0F);
		// Each internal fault source, and earth fault shown as overcurrent
		sel(14'h005B, 14'h00BF, 14'h0063);
		for (k = 0; k < 8; k++) begin
			@(posedge clk_i);
			flt <= pm[k];
			@(posedge clk_i);
			flt <= 11'h000;
			st(3'b101, 8'h0C, 8'h0C);
			wr(out_term_pkg::OFF_FCTL, 32'h1);
			st(3'b010, 8'h00, 8'h0C);
		end
		// Remote bits with both polarities
		sel(14'h0060, 14'h00C4, 14'h0060);
		for (k = 0; k < 2; k++) begin
			wr(out_term_pkg::OFF_REMOTE, {29'h0, r[2:0]});
			st({r[2], !r[1], r[0]}, 8'h00, 8'h00);
			r = ~r;
		end
		// Minor alarm on all terminals; inverted on the relay
		sel(14'h0062, 14'h0062, 14'h00C6);
		for (k = 0; k < 2; k++) begin
			@(posedge clk_i);
			flt <= 11'h200 << k;
			st(3'b011, 8'h20, 8'h20);
			@(posedge clk_i);
			flt <= 11'h000;
			st(3'b100, 8'h00, 8'h20);
		end
		// Maintenance count reaching its threshold
		wr(out_term_pkg::OFF_SEL0, 32'(out_term_pkg::F_MAINT));
		wr(out_term_pkg::OFF_MTHR, 32'h2);
		wr(out_term_pkg::OFF_MCOUNT, 32'h1);
		st(3'b100, 8'h00, 8'h10);
		@(posedge clk_i);
		tick <= 1'b1;
		@(posedge clk_i);
		tick <= 1'b0;
		st(3'b101, 8'h10, 8'h10);
		rd(out_term_pkg::OFF_MCOUNT, 32'h2);
		// Refused codes, then the no-function code
		wr(sel2_a, 32'(out_term_pkg::F_PULSE));
		rd(sel2_a, 32'h00C6);
		wr(out_term_pkg::OFF_SEL0, 32'h00FA);
		rd(out_term_pkg::OFF_SEL0, 32'(out_term_pkg::F_MAINT));
		wr(out_term_pkg::OFF_SEL0, 32'(out_term_pkg::NO_FUNC));
		st(3'b100, 8'h10, 8'h10);
		// Pulse train of the averaged current on an open collector
		@(posedge clk_i);
		avg <= 8'($urandom_range(1, 200));
		wr(sel1_a, 32'(out_term_pkg::F_PULSE));
		rd(sel1_a, 32'(out_term_pkg::F_PULSE));
		repeat (520) @(posedge clk_i);
		clr <= 1'b1;
		@(posedge clk_i);
		clr <= 1'b0;
		repeat (512) @(posedge clk_i);
		@(negedge clk_i);
		check("pulse_count", 32'(avg), 32'(on_cnt));
		summarize();
	end
endmodule : test_output_terminal_status_select
